/* hw/adcpp_defs.svh */
// Register map, field positions and pattern codes of the channel 5-8 post-processing block
// Notes on behaviour
// - With gain enabled, lane 8 samples get a gain of N x 0.2 dB, N from bits 15..11.
// - With offset enabled, the signed 10-bit offset in bits 9..0 is added to the lane 8 samples.
// - With per-lane select on, lanes 5..8 whose bit in 15..12 is set carry the random sequence.
// - With per-lane select on, lane 5 shows the pattern coded in 11..9, lane 6 that in 8..6.
// - With the filter on, y(n) = 2^k/(2^k+1) * (x(n) - x(n-1) + y(n-1)), k taken from bits 4..1.
// - Bit 0 enables the high-pass filter of lanes 5..8; at 0 (reset value) data pass unfiltered.
// - The lane 8 gain/offset register sits at index 1Fh, just before the offset copy.
`ifndef ADCPP_DEFS_SVH
`define ADCPP_DEFS_SVH

// Register indices; byte address is four times the index
`define ADCPP_IDX_GAIN_OFFSET 10'h01f
`define ADCPP_IDX_OFFSET_COPY 10'h020
`define ADCPP_IDX_LANE_PAT    10'h021
`define ADCPP_IDX_GLOBAL_CTL  10'h030
`define ADCPP_IDX_LANE8_STAT  10'h031

`define ADCPP_GAIN_MSB        15
`define ADCPP_GAIN_LSB        11
`define ADCPP_OFS_MSB         9
`define ADCPP_OFS_LSB         0
`define ADCPP_PRBS_EN_MSB     15
`define ADCPP_PAT5_MSB        11
`define ADCPP_PAT5_LSB        9
`define ADCPP_PAT6_MSB        8
`define ADCPP_PAT6_LSB        6
`define ADCPP_HPFK_MSB        4
`define ADCPP_HPFK_LSB        1
`define ADCPP_HPFEN_BIT       0

`define ADCPP_CTL_GAIN_BIT    0
`define ADCPP_CTL_OFS_BIT     1
`define ADCPP_CTL_PATSEL_BIT  2

`define ADCPP_REG_RESET       16'h0000
`define ADCPP_PRBS_SEED       23'h7fffff

`define ADCPP_PAT_NORMAL      3'h0
`define ADCPP_PAT_ZEROS       3'h1
`define ADCPP_PAT_ONES        3'h2
`define ADCPP_PAT_TOGGLE      3'h3
`define ADCPP_PAT_RAMP        3'h4
`define ADCPP_PAT_FIVES       3'h5
`define ADCPP_PAT_TENS        3'h6
`define ADCPP_PAT_DESKEW      3'h7

`endif

/* hw/adcpp_pkg.sv */
// Types of the channel 5-8 post-processing block
`include "adcpp_defs.svh"
package adcpp_pkg;
	typedef logic [15:0] adcpp_sample_type;
	typedef struct packed {
		logic [15:0]       gainOffset;
		logic [15:0]       offsetCopy;
		logic [15:0]       lanePattern;
		logic [2:0]        globalCtl;
		logic [3:0][15:0]  prevX;
		logic [3:0][25:0]  hpfY;
		logic [3:0][15:0]  laneData;
		logic              laneValid;
		logic [22:0]       prbs;
		logic [15:0]       ramp;
		logic              toggle;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
	} adcpp_state_type;
endpackage

/* hw/adcpp_post_process.sv */
// Lane 8 digital gain and offset, lanes 5-8 high-pass filter and test patterns behind an APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adcpp_defs.svh"
module adcpp_post_process (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire adcpp_pkg::adcpp_sample_type sampleIn [4],
	input  wire logic                        sampleValid,
	output adcpp_pkg::adcpp_sample_type      laneData [4],
	output logic                             laneValid
);
	import adcpp_pkg::*;

	// 2^14 * 10^(N*0.2/20), unity is 16'h4000
	localparam logic [16:0] GAIN_TABLE [32] = '{
		17'h04000, 17'h0417e, 17'h04304, 17'h04494, 17'h0462d, 17'h047cf, 17'h0497b, 17'h04b32,
		17'h04cf2, 17'h04ebd, 17'h05092, 17'h05273, 17'h0545e, 17'h05655, 17'h05858, 17'h05a67,
		17'h05c82, 17'h05eaa, 17'h060de, 17'h06320, 17'h0656f, 17'h067cc, 17'h06a37, 17'h06cb0,
		17'h06f38, 17'h071cf, 17'h07476, 17'h0772c, 17'h079f3, 17'h07cca, 17'h07fb2, 17'h082ac};
	// 2^16 * 2^k/(2^k+1); entries outside 2..10 exist only so any k is defined
	localparam logic [16:0] HPF_TABLE [16] = '{
		17'h08000, 17'h0aaab, 17'h0cccd, 17'h0e38e, 17'h0f0f1, 17'h0f83e, 17'h0fc10, 17'h0fe03,
		17'h0ff01, 17'h0ff80, 17'h0ffc0, 17'h0ffe0, 17'h0fff0, 17'h0fff8, 17'h0fffc, 17'h0fffe};

	adcpp_state_type state_r;
	adcpp_state_type state_nxt;

	logic              gainOn;
	logic              ofsOn;
	logic              patSel;
	logic              hpfOn;
	logic [16:0]       gainCoef;
	logic [16:0]       hpfCoef;
	logic signed [18:0] ofsExt;
	logic [3:0][15:0]  corrected;
	logic [3:0][25:0]  hpfNext;
	logic [3:0][15:0]  laneWord;
	logic              apbAccess;
	logic [9:0]        regIdx;
	logic              regHit;
	logic [31:0]       readWord;

	function automatic logic [15:0] sat16(input logic signed [18:0] v);
		if (v > 19'sh07fff)
			return 16'h7fff;
		else if (v < -19'sh08000)
			return 16'h8000;
		else
			return v[15:0];
	endfunction

	function automatic logic [15:0] patWord(input logic [2:0] code, input logic [15:0] data,
			input logic tgl, input logic [15:0] ramp);
		case (code)
			`ADCPP_PAT_NORMAL: return data;
			`ADCPP_PAT_ZEROS:  return 16'h0000;
			`ADCPP_PAT_ONES:   return 16'hffff;
			`ADCPP_PAT_TOGGLE: return tgl ? 16'haaaa : 16'h5555;
			`ADCPP_PAT_RAMP:   return ramp;
			`ADCPP_PAT_FIVES:  return 16'h5555;
			`ADCPP_PAT_TENS:   return 16'haaaa;
			default:           return 16'h00ff;
		endcase
	endfunction

	assign gainOn   = state_r.globalCtl[`ADCPP_CTL_GAIN_BIT];
	assign ofsOn    = state_r.globalCtl[`ADCPP_CTL_OFS_BIT];
	assign patSel   = state_r.globalCtl[`ADCPP_CTL_PATSEL_BIT];
	assign hpfOn    = state_r.lanePattern[`ADCPP_HPFEN_BIT];
	assign gainCoef = GAIN_TABLE[state_r.gainOffset[`ADCPP_GAIN_MSB:`ADCPP_GAIN_LSB]];
	assign hpfCoef  = HPF_TABLE[state_r.lanePattern[`ADCPP_HPFK_MSB:`ADCPP_HPFK_LSB]];
	// Offset taken from the gain/offset word; the copy is kept coherent by software
	assign ofsExt   = 19'($signed(state_r.gainOffset[`ADCPP_OFS_MSB:`ADCPP_OFS_LSB]));

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_lane
			logic signed [15:0] xIn;
			logic signed [17:0] gainSel;
			logic signed [33:0] gainProd;
			logic signed [18:0] withOfs;
			logic signed [16:0] diff;
			logic signed [26:0] hpfSum;
			logic signed [43:0] hpfProd;
			logic signed [18:0] yOut;
			logic [15:0]        procWord;
			logic [2:0]         code;
			logic [15:0]        laneOut;

			assign xIn      = sampleIn[ch];
			// Only lane 8 has its gain and offset in this block; other lanes run at unity
			assign gainSel  = (ch == 3 && gainOn) ? $signed({1'b0, gainCoef}) : 18'sh04000;
			assign gainProd = xIn * gainSel;
			// Sign of the product must survive the widening, or negative samples saturate high
			assign withOfs  = 19'($signed(gainProd[31:14]))
					+ ((ch == 3 && ofsOn) ? ofsExt : 19'sh0);
			assign corrected[ch] = sat16(withOfs);
			// Eight fraction bits in the feedback keep the pole from drifting on small inputs
			assign diff     = $signed(corrected[ch]) - $signed(state_r.prevX[ch]);
			assign hpfSum   = 27'($signed({diff, 8'h00})) + 27'($signed(state_r.hpfY[ch]));
			assign hpfProd  = hpfSum * $signed({1'b0, hpfCoef});
			assign hpfNext[ch] = hpfProd[41:16];
			assign yOut     = 19'($signed(hpfNext[ch][25:8]));
			assign procWord = hpfOn ? sat16(yOut) : corrected[ch];
			if (ch == 0) begin : g_code5
				assign code = state_r.lanePattern[`ADCPP_PAT5_MSB:`ADCPP_PAT5_LSB];
			end else if (ch == 1) begin : g_code6
				assign code = state_r.lanePattern[`ADCPP_PAT6_MSB:`ADCPP_PAT6_LSB];
			end else begin : g_codex
				assign code = `ADCPP_PAT_NORMAL;
			end
			always_comb begin
				if (!patSel)
					laneOut = procWord;
				else if (state_r.lanePattern[`ADCPP_PRBS_EN_MSB - ch])
					laneOut = state_r.prbs[15:0];
				else
					laneOut = patWord(code, procWord, state_r.toggle, state_r.ramp);
			end
			assign laneWord[ch] = laneOut;
		end
	endgenerate

	assign apbAccess = psel && penable;
	assign regIdx    = paddr[11:2];
	assign regHit    = regIdx == `ADCPP_IDX_GAIN_OFFSET || regIdx == `ADCPP_IDX_OFFSET_COPY
			|| regIdx == `ADCPP_IDX_LANE_PAT || regIdx == `ADCPP_IDX_GLOBAL_CTL
			|| regIdx == `ADCPP_IDX_LANE8_STAT;

	always_comb begin
		case (regIdx)
			`ADCPP_IDX_GAIN_OFFSET: readWord = {16'h0000, state_r.gainOffset};
			`ADCPP_IDX_OFFSET_COPY: readWord = {16'h0000, state_r.offsetCopy};
			`ADCPP_IDX_LANE_PAT:    readWord = {16'h0000, state_r.lanePattern};
			`ADCPP_IDX_GLOBAL_CTL:  readWord = {29'h0, state_r.globalCtl};
			`ADCPP_IDX_LANE8_STAT:  readWord = {16'h0000, state_r.laneData[3]};
			default:                readWord = 32'h0;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.prbs = {state_r.prbs[21:0], state_r.prbs[22] ^ state_r.prbs[17]};
		state_nxt.laneValid = sampleValid;
		if (sampleValid) begin
			state_nxt.ramp   = state_r.ramp + 16'h0001;
			state_nxt.toggle = !state_r.toggle;
			for (int i = 0; i < 4; i++) begin
				state_nxt.prevX[i]    = corrected[i];
				// Filter memory is cleared while bypassed so enabling starts from rest
				state_nxt.hpfY[i]     = hpfOn ? hpfNext[i] : 26'h0;
				state_nxt.laneData[i] = laneWord[i];
			end
		end
		// One wait state: answer is registered in the first access cycle, shown in the second and taken at the edge that ends it
		if (apbAccess && !state_r.pready) begin
			state_nxt.pready  = 1'b1;
			state_nxt.pslverr = !regHit;
			state_nxt.prdata  = pwrite ? 32'h0 : readWord;
		end else begin
			state_nxt.pready  = 1'b0;
			state_nxt.pslverr = 1'b0;
		end
		if (apbAccess && state_r.pready && pwrite) begin
			case (regIdx)
				`ADCPP_IDX_GAIN_OFFSET: state_nxt.gainOffset  = pwdata[15:0];
				`ADCPP_IDX_OFFSET_COPY: state_nxt.offsetCopy  = pwdata[15:0];
				`ADCPP_IDX_LANE_PAT:    state_nxt.lanePattern = pwdata[15:0];
				`ADCPP_IDX_GLOBAL_CTL:  state_nxt.globalCtl   = pwdata[2:0];
				default: ;
			endcase
		end
		if (rst) begin
			state_nxt = '0;
			state_nxt.gainOffset  = `ADCPP_REG_RESET;
			state_nxt.offsetCopy  = `ADCPP_REG_RESET;
			state_nxt.lanePattern = `ADCPP_REG_RESET;
			state_nxt.prbs        = `ADCPP_PRBS_SEED;
		end
	end

	always_ff @(posedge clk) begin
		state_r <= state_nxt;
	end

	assign prdata    = state_r.prdata;
	assign pready    = state_r.pready;
	assign pslverr   = state_r.pslverr;
	assign laneValid = state_r.laneValid;
	for (genvar o = 0; o < 4; o++) begin : g_out
		assign laneData[o] = state_r.laneData[o];
	end
endmodule

/* test/adcpp_checker.sv */
// Port-level assertions of the lane post-processing block
`timescale 1ns/1ps
module adcpp_checker (
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic [31:0]                 prdata,
	input wire logic                        sampleValid,
	input wire adcpp_pkg::adcpp_sample_type laneData [4],
	input wire logic                        laneValid
);
	import adcpp_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_LANE_LATENCY: assert property (sampleValid |=> laneValid)
		else $error("lane word missing one cycle after a sample");
	AST_LANE_QUIET: assert property (!sampleValid |=> !laneValid)
		else $error("lane valid without a sample");
	AST_LANE_HOLD: assert property (!laneValid |->
		$stable(laneData[0]) && $stable(laneData[1])
		&& $stable(laneData[2]) && $stable(laneData[3]))
		else $error("lane word changed between samples");
	AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("register access not answered after one wait");
	AST_SETUP_QUIET: assert property (psel && !penable |=> !pready)
		else $error("answer during setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_IDLE_QUIET: assert property (!psel |=> !pready)
		else $error("ready without selection");
	AST_ERR_FORM: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
endmodule

/* test/adcpp_lane_sink.sv */
// Receiving side of the four lanes: keeps the last word set and counts sets
`timescale 1ns/1ps
module adcpp_lane_sink (
	input wire logic                        clk,
	input wire adcpp_pkg::adcpp_sample_type laneData [4],
	input wire logic                        laneValid,
	output adcpp_pkg::adcpp_sample_type     got [4],
	output int                              count
);
	import adcpp_pkg::*;
	always @(posedge clk) begin
		if (laneValid === 1'b1) begin
			got <= laneData;
			count <= count + 1;
		end
	end
endmodule

/* test/tb_adcpp_post_process.sv */
// Self-checking bench of the lane post-processing block
`timescale 1ns/1ps
module tb_adcpp_post_process;
	import adcpp_pkg::*;
	logic             clk, rst, psel, penable, pwrite, sampleValid, pready, pslverr, laneValid, e;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	adcpp_sample_type sampleIn [4];
	adcpp_sample_type laneData [4];
	adcpp_sample_type got [4];
	adcpp_sample_type prev;
	adcpp_sample_type patExp [8] = '{16'h03e8, 16'h0, 16'hffff, 16'h0,
		16'h0, 16'h5555, 16'haaaa, 16'h00ff};
	int               errors, cmp_count, cyc, sinkCount, sends;
	adcpp_post_process i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sampleIn(sampleIn), .sampleValid(sampleValid),
		.laneData(laneData), .laneValid(laneValid));
	adcpp_lane_sink i_sink (.clk(clk), .laneData(laneData), .laneValid(laneValid),
		.got(got), .count(sinkCount));
	task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
		cmp_count++;
		if (act !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
		end
	endtask
	task automatic near(input adcpp_sample_type act, input int exp, input string what);
		int d;
		d = int'($signed(act)) - exp;
		check(32'(d >= -1 && d <= 1), 32'h1, what);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No wait count assumed; a hang is caught by the cycle ceiling
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Lanes 5 to 7 get v, lane 8 gets w; returns once the sink holds the result
	task automatic send(input int v, input int w);
		@(posedge clk);
		sampleValid <= 1'b1;
		for (int i = 0; i < 4; i++)
			sampleIn[i] <= 16'(i == 3 ? w : v);
		@(posedge clk);
		sampleValid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		sends++;
	endtask
	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Generous ceiling: the sequence needs well under 2000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, sampleValid, paddr, pwdata} = '0;
		sampleIn = '{default: 16'h0};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 12'h07c + 12'(4 * i), 32'h0);
			check(rd, 32'h0, "reset value");
		end
		apb(1'b0, 12'h100, 32'h0);
		check(32'(e), 32'h1, "unmapped");
		apb(1'b1, 12'h084, 32'h5);
		send(1000, 1000);
		near(got[0], 800, "hpf first");
		near(got[3], 800, "hpf lane8");
		send(1000, 1000);
		near(got[0], 640, "hpf second");
		send(-1000, -1000);
		near(got[2], -1088, "hpf negative");
		apb(1'b1, 12'h084, 32'h0);
		send(1000, 1000);
		check(got[0], 16'd1000, "hpf off");
		check(got[2], 16'd1000, "hpf off lane7");
		apb(1'b1, 12'h07c, 32'hf3ff);
		apb(1'b1, 12'h080, 32'h03ff);
		apb(1'b0, 12'h07c, 32'h0);
		check(rd, 32'hf3ff, "gain reg");
		apb(1'b0, 12'h080, 32'h0);
		check(rd, 32'h03ff, "copy reg");
		send(1000, 1000);
		check(got[3], 16'd1000, "enables off");
		apb(1'b1, 12'h0c0, 32'h2);
		send(1000, 1000);
		check(got[3], 16'd999, "offset");
		check(got[0], 16'd1000, "offset lane5");
		apb(1'b0, 12'h0c4, 32'h0);
		check(rd, 32'd999, "lane8 status");
		apb(1'b0, 12'h0c0, 32'h0);
		check(rd, 32'h2, "control reg");
		apb(1'b1, 12'h0c0, 32'h1);
		send(1000, 1000);
		near(got[3], 1995, "gain");
		apb(1'b1, 12'h0c0, 32'h4);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h084, 32'(c) * 32'h240);
			send(1000, 0);
			prev = got[0];
			send(1000, 0);
			if (c == 3)
				check(got[0] ^ prev, 16'hffff, "toggle");
			else if (c == 4)
				check(16'(got[0] - prev), 16'h1, "ramp");
			else begin
				check(got[0], patExp[c], "lane5 code");
				check(got[1], patExp[c], "lane6 code");
			end
		end
		apb(1'b1, 12'h084, 32'hf000);
		send(1000, 1000);
		prev = got[0];
		send(1000, 1000);
		check(32'(got[0] !== prev && got[3] !== 16'd1000), 32'h1, "prbs");
		check(got[1], got[0], "prbs lane6");
		check(got[2], got[0], "prbs lane7");
		apb(1'b1, 12'h0c0, 32'h0);
		send(1000, 1000);
		check(got[0], 16'd1000, "select off");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h084, 32'h0);
		check(rd, 32'h0, "reset pattern reg");
		send(1000, 1000);
		check(got[2], 16'd1000, "after reset");
		check(sinkCount, sends, "lane sets");
		report_and_stop();
	end
endmodule
bind adcpp_post_process adcpp_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.sampleValid(sampleValid), .laneData(laneData), .laneValid(laneValid));
